/* hw/timer_page_pkg.sv */
/*
 register map, field layout and reset values of the timer reload,
 timer count, page select and test configuration bank.
 assumes byte-wide registers placed one per 32-bit avalon word.
*/
// Behaviour
// - reload copied into counter only at start
// - reload built from high and low bytes
// - count readable as two read-only bytes
// - page enabled: page field gives A5..A4
// - page disabled: latch gives whole address
// - page bits 6..2 reserved, read zero
// - secure clock source select in bits 5..4
// - bit 3 drives secure clock onto D1 while the parallel host is unused
// - bits 2..0 pick probe bit for output
// - config two: reorder, prbs enables, bus select
// - prbs enable arms, send command starts it
// - reorder maps probe bus D4,D3,D2,D6,D5,D0,D1; code puts bus bits 3,4,0,1,2,6,5 on probe_port 6..0
package timer_page_pkg;
    // ==========================================
    // register indices, byte address = 4 * index
    localparam logic [5:0] idx_reload_high = 6'h2C;
    localparam logic [5:0] idx_reload_low = 6'h2D;
    localparam logic [5:0] idx_count_high = 6'h2E;
    localparam logic [5:0] idx_count_low = 6'h2F;
    localparam logic [5:0] idx_page = 6'h30;
    localparam logic [5:0] idx_test_one = 6'h31;
    localparam logic [5:0] idx_test_two = 6'h32;
    // ==========================================
    // reset values
    localparam logic [7:0] rst_byte = 8'h00;
    // ==========================================
    // field positions
    localparam int page_enable_bit = 7;
    localparam logic [7:0] page_write_mask = 8'h83;
    localparam logic [7:0] test_one_mask = 8'hFF;
    localparam int clk_on_line1_bit = 3;
    localparam int reorder_bit = 7;
    localparam int prbs_nine_enable_bit = 6;
    localparam int prbs_fifteen_enable_bit = 5;
    // ==========================================
    // secure clock sources
    typedef enum logic [1:0] {
        src_off = 2'h0,
        src_osc = 2'h1,
        src_uart = 2'h2,
        src_rf = 2'h3
    } clock_source_t;
    typedef enum logic [1:0] {
        st_idle,
        st_read,
        st_done
    } bus_state_t;
endpackage

/* hw/timer_down_counter.sv */
/*
 16-bit down counter of the timer unit, loaded only at a start event.
 assumes start and tick are single-cycle pulses on clk_sys.
*/
`timescale 1ns/1ps
module timer_down_counter import timer_page_pkg::*; #(
    parameter int width = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // control
    input wire logic start,
    input wire logic tick,
    input wire logic [width-1:0] reload_value,
    // state
    output logic [width-1:0] count
);
    logic [width-1:0] next_count;

    always_comb begin
        next_count = count;
        if (start) begin
            next_count = reload_value;
        end else if (tick && count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    a_load_on_start: assert property (@(posedge clk_sys) disable iff (!rstn)
        start |=> count == $past(reload_value))
        else $error("count not loaded at start");
    a_hold_no_start: assert property (@(posedge clk_sys) disable iff (!rstn)
        !start && !tick |=> $stable(count))
        else $error("count moved without start or tick");
endmodule

/* hw/timer_page_regs.sv */
/*
 timer reload/count registers, page select and test configuration
 bank behind an avalon-mm slave, plus the pin-side address forming.
 assumes the host interface delivers its address latch and pins
 already synchronous to clk_sys; the probe bus comes from on-chip logic.
*/
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module timer_page_regs import timer_page_pkg::*; #(
    parameter int count_width = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // timer events
    input wire logic timer_start,
    input wire logic timer_tick,
    // host address forming
    input wire logic [5:0] addr_latch,
    input wire logic [3:0] addr_pins,
    input wire logic host_access,
    output logic [5:0] host_reg_addr,
    output logic pins_by_detection,
    // secure clock
    input wire logic clk_osc,
    input wire logic clk_uart,
    input wire logic clk_rf,
    input wire logic parallel_host_used,
    output logic secure_clock,
    output logic line1_out,
    output logic line1_oe,
    // probe bus
    input wire logic [7:0] probe_bus,
    output logic signal_output_pin,
    output logic [6:0] probe_port,
    output logic [4:0] probe_bus_select,
    output logic prbs_nine_enable,
    output logic prbs_fifteen_enable
);
    // ==========================================
    // registers
    logic [7:0] reload_upper_byte, next_reload_upper_byte;
    logic [7:0] reload_lower_byte, next_reload_lower_byte;
    logic [7:0] page_reg, next_page_reg;
    logic [7:0] test_one, next_test_one;
    logic [7:0] test_two, next_test_two;
    logic [31:0] next_readdata;
    bus_state_t state, next_state;
    logic [count_width-1:0] count;
    logic [15:0] reload_value;
    logic [5:0] idx;
    logic page_enable;
    logic [1:0] page_field;
    logic [7:0] rd_byte;

    assign idx = avs_address[7:2];
    assign reload_value = {reload_upper_byte, reload_lower_byte};

    timer_down_counter #(
        .width(count_width)
    ) u_timer_down_counter (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(timer_start),
        .tick(timer_tick),
        .reload_value(reload_value),
        .count(count)
    );

    // ==========================================
    // read mux; unmapped indices read zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            idx_reload_high: rd_byte = reload_upper_byte;
            idx_reload_low: rd_byte = reload_lower_byte;
            idx_count_high: rd_byte = count[15:8];
            idx_count_low: rd_byte = count[7:0];
            idx_page: rd_byte = page_reg & page_write_mask;
            idx_test_one: rd_byte = test_one;
            idx_test_two: rd_byte = test_two;
            default: rd_byte = 8'h00;
        endcase
    end

    // ==========================================
    // bus slave: writes in one cycle, reads take three (two wait states)
    always_comb begin
        next_state = state;
        next_readdata = avs_readdata;
        next_reload_upper_byte = reload_upper_byte;
        next_reload_lower_byte = reload_lower_byte;
        next_page_reg = page_reg;
        next_test_one = test_one;
        next_test_two = test_two;
        unique case (state)
            st_idle: begin
                if (avs_read) begin
                    next_state = st_read;
                end else if (avs_write) begin
                    // count registers have no write path
                    unique case (idx)
                        idx_reload_high:
                            next_reload_upper_byte = avs_writedata[7:0];
                        idx_reload_low:
                            next_reload_lower_byte = avs_writedata[7:0];
                        idx_page:
                            next_page_reg = avs_writedata[7:0]
                                & page_write_mask;
                        idx_test_one:
                            next_test_one = avs_writedata[7:0]
                                & test_one_mask;
                        idx_test_two:
                            next_test_two = avs_writedata[7:0];
                        default: next_state = st_idle;
                    endcase
                end
            end
            st_read: begin
                next_readdata = {24'h000000, rd_byte};
                next_state = st_done;
            end
            st_done: next_state = st_idle;
        endcase
    end

    always_comb begin
        avs_waitrequest = 1'b0;
        if (avs_read) begin
            avs_waitrequest = (state != st_done);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= st_idle;
            avs_readdata <= 32'h00000000;
            reload_upper_byte <= rst_byte;
            reload_lower_byte <= rst_byte;
            page_reg <= rst_byte;
            test_one <= rst_byte;
            test_two <= rst_byte;
        end else begin
            state <= next_state;
            avs_readdata <= next_readdata;
            reload_upper_byte <= next_reload_upper_byte;
            reload_lower_byte <= next_reload_lower_byte;
            page_reg <= next_page_reg;
            test_one <= next_test_one;
            test_two <= next_test_two;
        end
    end

    // ==========================================
    // host address forming; page is registered, so a page write
    // only steers accesses after it
    assign page_enable = page_reg[page_enable_bit];
    assign page_field = page_reg[1:0];
    logic [5:0] next_host_reg_addr;
    logic next_pins_by_detection;
    always_comb begin
        next_host_reg_addr = host_reg_addr;
        next_pins_by_detection = pins_by_detection;
        if (host_access) begin
            if (page_enable) begin
                next_host_reg_addr = {page_field, addr_pins};
                next_pins_by_detection = 1'b0;
            end else begin
                next_host_reg_addr = addr_latch;
                next_pins_by_detection = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            host_reg_addr <= 6'h00;
            pins_by_detection <= 1'b1;
        end else begin
            host_reg_addr <= next_host_reg_addr;
            pins_by_detection <= next_pins_by_detection;
        end
    end

    // ==========================================
    // secure clock source; a plain mux, glitches at switch-over
    // are tolerated as the source changes only under software control
    clock_source_t src;
    assign src = clock_source_t'(test_one[5:4]);
    always_comb begin
        unique case (src)
            src_off: secure_clock = 1'b0;
            src_osc: secure_clock = clk_osc;
            src_uart: secure_clock = clk_uart;
            src_rf: secure_clock = clk_rf;
        endcase
    end
    // line1 drive is gated off here while the parallel bus is used
    assign line1_oe = test_one[clk_on_line1_bit] & ~parallel_host_used;
    assign line1_out = line1_oe & secure_clock;

    // ==========================================
    // probe outputs
    logic next_sig;
    logic [6:0] next_probe_port;
    always_comb begin
        next_sig = probe_bus[test_one[2:0]];
        if (test_two[reorder_bit]) begin
            // port line k carries bus bit listed at position k
            next_probe_port = {probe_bus[3], probe_bus[4], probe_bus[0],
                probe_bus[1], probe_bus[2], probe_bus[6],
                probe_bus[5]};
        end else begin
            next_probe_port = probe_bus[6:0];
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            signal_output_pin <= 1'b0;
            probe_port <= 7'h00;
        end else begin
            signal_output_pin <= next_sig;
            probe_port <= next_probe_port;
        end
    end
    // enables only arm the generator; the send command starts it
    assign prbs_nine_enable = test_two[prbs_nine_enable_bit];
    assign prbs_fifteen_enable = test_two[prbs_fifteen_enable_bit];
    assign probe_bus_select = test_two[4:0];

    // ==========================================
    // checks
    sequence s_read_req;
        avs_read && state == st_idle;
    endsequence
    sequence s_read_done;
        ##2 !avs_waitrequest;
    endsequence
    a_read_latency: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_read_req |-> s_read_done)
        else $error("read not answered in two cycles");
    a_page_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
        page_reg[6:2] == 5'h00)
        else $error("reserved page bits set");
    a_page_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
        host_access && page_enable |=>
        host_reg_addr == {$past(page_field), $past(addr_pins)})
        else $error("paged address wrong");
    a_latch_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
        host_access && !page_enable |=>
        host_reg_addr == $past(addr_latch) && pins_by_detection)
        else $error("latched address wrong");
    a_count_nowrite: assert property (@(posedge clk_sys) disable iff (!rstn)
        avs_write && state == st_idle && idx == idx_count_low |=>
        $stable(reload_lower_byte) && $stable(page_reg))
        else $error("count write altered state");
    a_clock_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        test_one[5:4] == 2'h0 |-> !secure_clock && !line1_out)
        else $error("secure clock not off");
    a_line1_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
        line1_oe |-> test_one[clk_on_line1_bit] && !parallel_host_used)
        else $error("line1 driven illegally");
    a_sig_select: assert property (@(posedge clk_sys) disable iff (!rstn)
        1'b1 |=> signal_output_pin == $past(probe_bus[test_one[2:0]]))
        else $error("probe bit select wrong");
    a_reorder_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        test_two[reorder_bit] |=> probe_port[0] == $past(probe_bus[5])
        && probe_port[6] == $past(probe_bus[3]))
        else $error("reordered port wrong");
    a_prbs_arm: assert property (@(posedge clk_sys) disable iff (!rstn)
        prbs_nine_enable == test_two[prbs_nine_enable_bit]
        && probe_bus_select == test_two[4:0])
        else $error("config two fields wrong");
    a_reload_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        avs_write && state == st_idle && idx == idx_reload_low |=>
        reload_lower_byte == $past(avs_writedata[7:0]))
        else $error("reload low not written");
    sequence s_page_write;
        avs_write && state == st_idle && idx == idx_page;
    endsequence
    a_page_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_page_write |=> page_reg == ($past(avs_writedata[7:0])
        & page_write_mask))
        else $error("page write not applied");
    a_count_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        avs_read && !timer_start && !timer_tick |=> $stable(count))
        else $error("count disturbed by read");
    a_count_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == st_read && idx == idx_count_low |=>
        avs_readdata == {24'h000000, $past(count[7:0])})
        else $error("count read back wrong");
    a_line1_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
        !line1_oe |-> !line1_out)
        else $error("line1 active while released");
    a_write_ack: assert property (@(posedge clk_sys) disable iff (!rstn)
        avs_write |-> !avs_waitrequest)
        else $error("write stalled");
endmodule

/* tb/host_model.sv */
/*
 host model: avalon-mm master making single register accesses.
 assumes a slave with waitrequest on clk_sys and reset rstn.
*/
`timescale 1ns/1ps
module host_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // avalon-mm master
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // read results
    output logic rd_done,
    output logic [31:0] rd_data,
    output int timeouts
);
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        rd_done = 1'b0;
        rd_data = 32'h00000000;
        timeouts = 0;
    end
    // ==========================================
    // one access, held until waitrequest is seen low
    task automatic access(input logic [5:0] idx, input logic wr,
                          input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest && n < 20);
        if (avs_waitrequest) begin
            timeouts++;
        end else if (!wr) begin
            rd_data <= avs_readdata;
            rd_done <= 1'b1;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released data is scrambled so stale values are not trusted
        avs_writedata <= ~avs_writedata;
    endtask
    always @(posedge clk_sys) begin
        if (rd_done) begin
            rd_done <= 1'b0;
        end
    end
endmodule

/* tb/timer_page_test_regs_test.sv */
/*
 self-checking bench of the timer, page and test register bank.
 assumes the design answers reads in a few cycles and writes at once.
*/
`timescale 1ns/1ps
module timer_page_test_regs_test import timer_page_pkg::*;;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rd_data;
    logic timer_start = 1'b0, timer_tick = 1'b0, host_access = 1'b0;
    logic clk_osc = 1'b0, clk_uart = 1'b0, clk_rf = 1'b0;
    logic parallel_host_used = 1'b0, rd_done, obs_stb = 1'b0;
    logic [5:0] addr_latch = 6'h00, host_reg_addr;
    logic [3:0] addr_pins = 4'h0;
    logic [7:0] probe_bus = 8'h00, v;
    logic pins_by_detection, secure_clock, line1_out, line1_oe;
    logic signal_output_pin, prbs_nine_enable, prbs_fifteen_enable;
    logic [6:0] probe_port;
    logic [4:0] probe_bus_select;
    logic [31:0] obs_val = 32'h00000000, seed = 32'h0000004E, cs;
    logic [31:0] exp_q[$];
    logic [15:0] r, n;
    logic [3:0] src;
    logic [5:0] rv[5];
    int err_total = 0, checked = 0;

    always #10 clk_sys = ~clk_sys;

    timer_page_regs u_timer_page_regs (.clk_sys, .rstn, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .timer_start, .timer_tick, .addr_latch,
        .addr_pins, .host_access, .host_reg_addr, .pins_by_detection,
        .clk_osc, .clk_uart, .clk_rf, .parallel_host_used, .secure_clock,
        .line1_out, .line1_oe, .probe_bus, .signal_output_pin,
        .probe_port, .probe_bus_select, .prbs_nine_enable,
        .prbs_fifteen_enable);
    host_model u_host_model (.clk_sys, .rstn, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .rd_done, .rd_data, .timeouts());

    // ==========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic take(input logic [31:0] seen);
        if (exp_q.size() == 0) begin
            err_total++;
            $display("CHECK FAILED %0t unexpected result %h", $time, seen);
        end else begin
            check(seen, exp_q.pop_front());
        end
    endtask
    always @(posedge clk_sys) begin
        if (rd_done) begin
            take(rd_data);
        end
        if (obs_stb) begin
            take(obs_val);
        end
    end
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        u_host_model.access(i, 1'b1, d);
        if (u_host_model.timeouts != 0) begin
            results();
        end
    endtask
    task automatic rd(input logic [5:0] i, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        u_host_model.access(i, 1'b0, 8'h00);
        if (u_host_model.timeouts != 0) begin
            results();
        end
    endtask
    // samples a port one edge later, when prior writes have settled
    task automatic obs(input logic [31:0] e, input int sel);
        @(posedge clk_sys);
        exp_q.push_back(e);
        case (sel)
            0: obs_val <= {26'h0, host_reg_addr};
            1: obs_val <= {31'h0, pins_by_detection};
            2: obs_val <= {29'h0, secure_clock, line1_out, line1_oe};
            3: obs_val <= {31'h0, signal_output_pin};
            4: obs_val <= {25'h0, prbs_nine_enable, prbs_fifteen_enable,
                           probe_bus_select};
            default: obs_val <= {25'h0, probe_port};
        endcase
        obs_stb <= 1'b1;
        @(posedge clk_sys);
        obs_stb <= 1'b0;
    endtask
    task automatic results();
        err_total += u_host_model.timeouts + exp_q.size();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        rv = '{idx_reload_high, idx_reload_low, idx_page, idx_test_one,
               idx_test_two};
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (rv[k]) rd(rv[k], rst_byte);
        rd(6'h3F, 8'h00);
        r = 16'(rnd());
        r[0] = 1'b1;
        n = 16'(rnd());
        wr(idx_reload_high, r[15:8]);
        wr(idx_reload_low, r[7:0]);
        @(posedge clk_sys) timer_start <= 1'b1;
        @(posedge clk_sys) timer_start <= 1'b0;
        rd(idx_count_high, r[15:8]);
        rd(idx_count_low, r[7:0]);
        wr(idx_reload_high, n[15:8]);
        wr(idx_reload_low, n[7:0]);
        wr(idx_count_low, ~r[7:0]);
        @(posedge clk_sys) timer_tick <= 1'b1;
        @(posedge clk_sys) timer_tick <= 1'b0;
        r = r - 16'h0001;
        rd(idx_count_high, r[15:8]);
        rd(idx_count_low, r[7:0]);
        rd(idx_count_low, r[7:0]);
        @(posedge clk_sys) timer_start <= 1'b1;
        @(posedge clk_sys) timer_start <= 1'b0;
        rd(idx_count_high, n[15:8]);
        rd(idx_count_low, n[7:0]);
        rd(idx_reload_high, n[15:8]);
        // page select on, then off
        wr(idx_page, 8'hFF);
        rd(idx_page, 8'h83);
        cs = rnd();
        addr_pins <= cs[3:0];
        addr_latch <= cs[9:4];
        @(posedge clk_sys) host_access <= 1'b1;
        @(posedge clk_sys) host_access <= 1'b0;
        obs({26'h0, 2'b11, cs[3:0]}, 0);
        obs(32'h0, 1);
        wr(idx_page, 8'h01);
        @(posedge clk_sys) host_access <= 1'b1;
        @(posedge clk_sys) host_access <= 1'b0;
        obs({26'h0, cs[9:4]}, 0);
        obs(32'h1, 1);
        // secure clock sources and probe bit selection
        probe_bus <= cs[23:16];
        for (int i = 0; i < 8; i++) begin
            cs = rnd();
            {clk_rf, clk_uart, clk_osc} <= cs[2:0];
            src = {cs[2:0], 1'b0};
            v = {2'b00, i[1:0], 1'b1, i[2:0]};
            // line1 drive only while the parallel host is unused
            wr(idx_test_one, v);
            rd(idx_test_one, v);
            obs({29'h0, {2{src[i[1:0]]}}, 1'b1}, 2);
            obs({31'h0, probe_bus[i[2:0]]}, 3);
        end
        parallel_host_used <= 1'b1;
        obs({29'h0, src[3], 2'b00}, 2);
        // probe bus reorder, prbs arming and bus select
        for (int k = 0; k < 4; k++) begin
            cs = rnd();
            v = {k[0], cs[6:0]};
            wr(idx_test_two, v);
            rd(idx_test_two, v);
            obs({25'h0, v[6:0]}, 4);
            if (v[7]) begin
                obs({25'h0, probe_bus[3], probe_bus[4], probe_bus[0],
                     probe_bus[1], probe_bus[2], probe_bus[6],
                     probe_bus[5]}, 5);
            end else begin
                obs({25'h0, probe_bus[6:0]}, 5);
            end
        end
        repeat (3) @(posedge clk_sys);
        results();
    end
endmodule
